// >>> design/dual_image_upgrade_regs.sv
`timescale 1ns/1ns
`default_nettype none

module dual_image_upgrade_regs
  import upgrade_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_read,
  output logic [31:0] avs_readdata,
  output logic avs_readdatavalid,
  output logic upgrade_block_clock,
  output logic [1:0] upgrade_select,
  output logic upgrade_capture,
  output logic upgrade_update,
  output logic upgrade_shift,
  output logic upgrade_din,
  input wire logic upgrade_dout,
  output logic timer_reset_n,
  output logic reconfig_n
);

  typedef struct packed {
    ctrl_state_t state;
    logic busy;
    logic [FETCH_W-1:0] pending;
    logic [1:0] target;
    logic [1:0] select;
    logic capture;
    logic update;
    logic start;
    logic [LEN_W-1:0] len;
    logic [SHIFT_W-1:0] tx;
    logic [2:0] timer_hold;
    logic [2:0] reconfig_hold;
    logic timer_reset_n;
    logic reconfig_n;
    logic [WD_VALUE_W-1:0] wd_value;
    logic wd_enable;
    logic [NIBBLE_W-1:0] wd_state;
    logic [NIBBLE_W-1:0] p1_src;
    logic [NIBBLE_W-1:0] p1_state;
    logic [NIBBLE_W-1:0] p2_src;
    logic [NIBBLE_W-1:0] p2_state;
    logic rb_override;
    logic rb_select;
    logic [31:0] rdata;
    logic rvalid;
  } ctrl_regs_t;

  ctrl_regs_t cur_reg;
  ctrl_regs_t cur_next;

  logic tick;

  shift_if sh ();

  upgrade_clock_divider u_divider (
    .core_clk(core_clk),
    .srst(srst),
    .upgrade_block_clock(upgrade_block_clock),
    .tick(tick)
  );

  serial_shift_engine u_engine (
    .core_clk(core_clk),
    .srst(srst),
    .tick(tick),
    .sh(sh),
    .upgrade_dout(upgrade_dout),
    .upgrade_shift(upgrade_shift),
    .upgrade_din(upgrade_din)
  );

  // lowest pending target goes first
  function automatic logic [1:0] first_set(input logic [FETCH_W-1:0] mask);
    logic [1:0] r;
    r = TARGET_INPUT;
    for (int i = FETCH_W - 1; i >= 0; i--) begin
      if (mask[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [LEN_W-1:0] frame_len(input logic [1:0] target);
    logic [LEN_W-1:0] r;
    r = LEN_INPUT;
    unique case (target)
      TARGET_WATCHDOG: r = LEN_WATCHDOG;
      TARGET_PREV_ONE: r = LEN_PREV;
      TARGET_PREV_TWO: r = LEN_PREV;
      TARGET_INPUT: r = LEN_INPUT;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] read_word(input ctrl_regs_t c, input logic [2:0] ofs);
    logic [31:0] w;
    w = 32'h0;
    unique case (ofs)
      OFS_BUSY: w = {31'h0, c.busy};
      OFS_WATCHDOG: w = {15'h0, c.wd_state, c.wd_enable, c.wd_value};
      OFS_PREV_ONE: w = {24'h0, c.p1_state, c.p1_src};
      OFS_PREV_TWO: w = {24'h0, c.p2_state, c.p2_src};
      OFS_IMAGE_READBACK: w = {30'h0, c.rb_select, c.rb_override};
      OFS_COMMAND: w = 32'h0;
      OFS_IMAGE_SELECT: w = 32'h0;
      OFS_FETCH: w = 32'h0;
    endcase
    return w;
  endfunction

  always_comb begin
    cur_next = cur_reg;
    cur_next.start = 1'b0;
    cur_next.rvalid = 1'b0;
    if (cur_reg.timer_hold != 3'h0) begin
      cur_next.timer_hold = cur_reg.timer_hold - 3'h1;
    end
    if (cur_reg.reconfig_hold != 3'h0) begin
      cur_next.reconfig_hold = cur_reg.reconfig_hold - 3'h1;
    end

    unique case (cur_reg.state)
      ST_IDLE: begin
      end
      ST_LOAD_SHIFT: begin
        if (sh.done) begin
          cur_next.state = ST_LOAD_UPDATE;
        end
      end
      ST_LOAD_UPDATE: begin
        // update held for one full divided clock period
        if (tick) begin
          if (!cur_reg.update) begin
            cur_next.update = 1'b1;
          end else begin
            cur_next.update = 1'b0;
            cur_next.busy = 1'b0;
            cur_next.state = ST_IDLE;
          end
        end
      end
      ST_PICK: begin
        if (cur_reg.pending == '0) begin
          cur_next.busy = 1'b0;
          cur_next.state = ST_IDLE;
        end else if (tick) begin
          cur_next.target = first_set(cur_reg.pending);
          cur_next.select = first_set(cur_reg.pending);
          cur_next.capture = 1'b1;
          cur_next.state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (tick) begin
          cur_next.capture = 1'b0;
          cur_next.start = 1'b1;
          cur_next.len = frame_len(cur_reg.target);
          cur_next.tx = '0;
          cur_next.state = ST_FETCH_SHIFT;
        end
      end
      ST_FETCH_SHIFT: begin
        if (sh.done) begin
          cur_next.pending[cur_reg.target] = 1'b0;
          cur_next.state = ST_PICK;
          unique case (cur_reg.target)
            TARGET_WATCHDOG: begin
              cur_next.wd_value = sh.rx[WD_COUNT_TOP -: WD_VALUE_W];
              cur_next.wd_enable = sh.rx[WD_ENABLE_POS];
              cur_next.wd_state = sh.rx[WD_STATE_TOP -: NIBBLE_W];
            end
            TARGET_PREV_ONE: begin
              cur_next.p1_src = sh.rx[NIBBLE_W-1:0];
              cur_next.p1_state = sh.rx[2*NIBBLE_W-1:NIBBLE_W];
            end
            TARGET_PREV_TWO: begin
              cur_next.p2_src = sh.rx[NIBBLE_W-1:0];
              cur_next.p2_state = sh.rx[2*NIBBLE_W-1:NIBBLE_W];
            end
            TARGET_INPUT: begin
              cur_next.rb_override = sh.rx[IMG_OVERRIDE_BIT];
              cur_next.rb_select = sh.rx[IMG_SELECT_BIT];
            end
          endcase
        end
      end
      default: begin
        cur_next.state = ST_IDLE;
        cur_next.busy = 1'b0;
      end
    endcase

    if (avs_write) begin
      unique case (avs_address)
        OFS_COMMAND: begin
          if (avs_writedata[CMD_TIMER_RESET_BIT]) begin
            cur_next.timer_hold = PULSE_HOLD_CYCLES;
          end
          if (avs_writedata[CMD_RECONFIG_BIT] && !cur_reg.busy) begin
            cur_next.reconfig_hold = PULSE_HOLD_CYCLES;
          end
        end
        OFS_IMAGE_SELECT: begin
          if (!cur_reg.busy) begin
            cur_next.busy = 1'b1;
            cur_next.tx = {32'h0, avs_writedata[IMG_SELECT_BIT],
                           avs_writedata[IMG_OVERRIDE_BIT]};
            cur_next.len = LEN_INPUT;
            cur_next.select = TARGET_INPUT;
            cur_next.start = 1'b1;
            cur_next.state = ST_LOAD_SHIFT;
          end
        end
        OFS_FETCH: begin
          if (!cur_reg.busy && avs_writedata[FETCH_W-1:0] != '0) begin
            cur_next.busy = 1'b1;
            cur_next.pending = avs_writedata[FETCH_W-1:0];
            cur_next.state = ST_PICK;
          end
        end
        default: begin
        end
      endcase
    end

    cur_next.timer_reset_n = (cur_next.timer_hold == 3'h0);
    cur_next.reconfig_n = (cur_next.reconfig_hold == 3'h0);

    if (avs_read) begin
      cur_next.rvalid = 1'b1;
      cur_next.rdata = read_word(cur_reg, avs_address);
    end else begin
      cur_next.rdata = 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_reg <= '0;
      cur_reg.timer_reset_n <= 1'b1;
      cur_reg.reconfig_n <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign sh.start = cur_reg.start;
  assign sh.len = cur_reg.len;
  assign sh.tx = cur_reg.tx;

  assign avs_readdata = cur_reg.rdata;
  assign avs_readdatavalid = cur_reg.rvalid;
  assign upgrade_select = cur_reg.select;
  assign upgrade_capture = cur_reg.capture;
  assign upgrade_update = cur_reg.update;
  assign timer_reset_n = cur_reg.timer_reset_n;
  assign reconfig_n = cur_reg.reconfig_n;

endmodule // dual_image_upgrade_regs

`default_nettype wire

// >>> shared/upgrade_regs_pkg.sv
package upgrade_regs_pkg;

  // word offsets on the memory-mapped slave
  localparam logic [2:0] OFS_COMMAND = 3'h0;
  localparam logic [2:0] OFS_IMAGE_SELECT = 3'h1;
  localparam logic [2:0] OFS_FETCH = 3'h2;
  localparam logic [2:0] OFS_BUSY = 3'h3;
  localparam logic [2:0] OFS_WATCHDOG = 3'h4;
  localparam logic [2:0] OFS_PREV_ONE = 3'h5;
  localparam logic [2:0] OFS_PREV_TWO = 3'h6;
  localparam logic [2:0] OFS_IMAGE_READBACK = 3'h7;

  // write field positions
  localparam int CMD_RECONFIG_BIT = 0;
  localparam int CMD_TIMER_RESET_BIT = 1;
  localparam int IMG_OVERRIDE_BIT = 0;
  localparam int IMG_SELECT_BIT = 1;
  localparam int FETCH_W = 4;

  // fetch targets, equal to the fetch bit positions
  localparam logic [1:0] TARGET_WATCHDOG = 2'h0;
  localparam logic [1:0] TARGET_PREV_ONE = 2'h1;
  localparam logic [1:0] TARGET_PREV_TWO = 2'h2;
  localparam logic [1:0] TARGET_INPUT = 2'h3;

  // serial frame layouts, lsb first on the wire
  localparam int SHIFT_W = 34;
  localparam int LEN_W = 6;
  localparam logic [5:0] LEN_WATCHDOG = 6'h22;
  localparam logic [5:0] LEN_PREV = 6'h08;
  localparam logic [5:0] LEN_INPUT = 6'h02;
  localparam int WD_COUNT_TOP = 28;
  localparam int WD_VALUE_W = 12;
  localparam int WD_ENABLE_POS = 29;
  localparam int WD_STATE_TOP = 33;
  localparam int NIBBLE_W = 4;

  // upper bound on the busy period of one triggered operation, in core clocks
  localparam int MAX_BUSY_CYCLES = 531;
  // core clocks that timer reset and reconfiguration strobes stay low
  localparam logic [2:0] PULSE_HOLD_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD_SHIFT,
    ST_LOAD_UPDATE,
    ST_PICK,
    ST_CAPTURE,
    ST_FETCH_SHIFT
  } ctrl_state_t;

endpackage

// >>> shared/shift_if.sv
`timescale 1ns/1ns
`default_nettype none

interface shift_if;
  import upgrade_regs_pkg::*;
  logic start;
  logic [LEN_W-1:0] len;
  logic [SHIFT_W-1:0] tx;
  logic done;
  logic [SHIFT_W-1:0] rx;

  modport ctrl (output start, output len, output tx, input done, input rx);
  modport engine (input start, input len, input tx, output done, output rx);
endinterface

`default_nettype wire

// >>> design/upgrade_clock_divider.sv
`timescale 1ns/1ns
`default_nettype none

module upgrade_clock_divider
  import upgrade_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  output logic upgrade_block_clock,
  output logic tick
);

  typedef struct packed {
    logic clk;
    logic tick;
  } div_state_t;

  div_state_t cur_reg;
  div_state_t cur_next;

  // tick is high while the divided clock is high, so the
  // controller changes its outputs during the low half
  always_comb begin
    cur_next = cur_reg;
    cur_next.clk = ~cur_reg.clk;
    cur_next.tick = ~cur_reg.clk;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign upgrade_block_clock = cur_reg.clk;
  assign tick = cur_reg.tick;

endmodule // upgrade_clock_divider

`default_nettype wire

// >>> design/serial_shift_engine.sv
`timescale 1ns/1ns
`default_nettype none

module serial_shift_engine
  import upgrade_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tick,
  shift_if.engine sh,
  input wire logic upgrade_dout,
  output logic upgrade_shift,
  output logic upgrade_din
);

  typedef struct packed {
    logic active;
    logic [LEN_W-1:0] count;
    logic [LEN_W-1:0] len;
    logic [SHIFT_W-1:0] sr;
    logic shift;
    logic din;
    logic done;
  } eng_state_t;

  eng_state_t cur_reg;
  eng_state_t cur_next;

  // one bit per divided clock; the far chain shows its current lsb on
  // dout, which is sampled before the rising edge that shifts it
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    if (sh.start) begin
      cur_next.active = 1'b1;
      cur_next.count = sh.len;
      cur_next.len = sh.len;
      cur_next.sr = sh.tx;
    end else if (cur_reg.active && tick) begin
      if (cur_reg.count != '0) begin
        cur_next.din = cur_reg.sr[0];
        cur_next.shift = 1'b1;
        cur_next.sr = cur_reg.sr >> 1;
        cur_next.sr[cur_reg.len - 6'h01] = upgrade_dout;
        cur_next.count = cur_reg.count - 6'h01;
      end else begin
        cur_next.shift = 1'b0;
        cur_next.active = 1'b0;
        cur_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign upgrade_shift = cur_reg.shift;
  assign upgrade_din = cur_reg.din;
  assign sh.done = cur_reg.done;
  assign sh.rx = cur_reg.sr;

endmodule // serial_shift_engine

`default_nettype wire

// >>> tb/upgrade_block_model.sv
`timescale 1ns/1ns
`default_nettype none

module upgrade_block_model
  import upgrade_regs_pkg::*;
#(
  parameter logic [28:0] WD_COUNT = 29'h0,
  parameter logic WD_EN = 1'b0,
  parameter logic [3:0] WD_STATE = 4'h0,
  parameter logic [7:0] PREV_ONE = 8'h0,
  parameter logic [7:0] PREV_TWO = 8'h0
)
(
  input wire logic upgrade_block_clock,
  input wire logic [1:0] upgrade_select,
  input wire logic upgrade_capture,
  input wire logic upgrade_update,
  input wire logic upgrade_shift,
  input wire logic upgrade_din,
  output logic upgrade_dout
);
  logic [33:0] chain = 34'h0;
  logic [33:0] shifted;
  logic [1:0] input_reg = 2'h0;
  logic [5:0] len;

  assign len = (upgrade_select == TARGET_WATCHDOG) ? LEN_WATCHDOG :
               (upgrade_select == TARGET_INPUT) ? LEN_INPUT : LEN_PREV;
  assign upgrade_dout = chain[0];

  // chain after one shift, new bit entering at the frame's top
  always_comb begin
    shifted = chain >> 1;
    shifted[len - 6'h1] = upgrade_din;
  end

  always @(posedge upgrade_block_clock) begin
    if (upgrade_capture) begin
      case (upgrade_select)
        TARGET_WATCHDOG: chain <= {WD_STATE, WD_EN, WD_COUNT};
        TARGET_PREV_ONE: chain <= {26'h0, PREV_ONE};
        TARGET_PREV_TWO: chain <= {26'h0, PREV_TWO};
        default: chain <= {32'h0, input_reg};
      endcase
    end else if (upgrade_shift) begin
      chain <= shifted;
    end
    if (upgrade_update && upgrade_select == TARGET_INPUT) begin
      input_reg <= chain[1:0];
    end
  end
endmodule // upgrade_block_model

`default_nettype wire

// >>> tb/dual_image_upgrade_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none

module dual_image_upgrade_regs_properties
  import upgrade_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_readdatavalid,
  input wire logic upgrade_block_clock,
  input wire logic [1:0] upgrade_select,
  input wire logic upgrade_capture,
  input wire logic upgrade_update,
  input wire logic timer_reset_n,
  input wire logic reconfig_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  logic cmd_wr;
  logic tmr_wr;
  logic rcf_wr;
  assign cmd_wr = avs_write && avs_address == OFS_COMMAND;
  assign tmr_wr = cmd_wr && avs_writedata[CMD_TIMER_RESET_BIT];
  assign rcf_wr = cmd_wr && avs_writedata[CMD_RECONFIG_BIT];

  property p_rd; avs_read |=> avs_readdatavalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_idle; !avs_readdatavalid |-> avs_readdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without valid");
  property p_busyw; avs_read && avs_address == OFS_BUSY |=> avs_readdata[31:1] == 31'h0;
  endproperty
  a_busyw: assert property (p_busyw) else $error("busy word reserved bits");
  property p_wdw; avs_read && avs_address == OFS_WATCHDOG |=> avs_readdata[31:17] == 15'h0;
  endproperty
  a_wdw: assert property (p_wdw) else $error("watchdog word reserved bits");
  property p_prevw; avs_read && (avs_address == OFS_PREV_ONE || avs_address == OFS_PREV_TWO)
    |=> avs_readdata[31:8] == 24'h0; endproperty
  a_prevw: assert property (p_prevw) else $error("previous word reserved bits");
  property p_imgw; avs_read && avs_address == OFS_IMAGE_READBACK |=> avs_readdata[31:2] == 30'h0;
  endproperty
  a_imgw: assert property (p_imgw) else $error("readback reserved bits");
  property p_thold; tmr_wr |=> !timer_reset_n [*4]; endproperty
  a_thold: assert property (p_thold) else $error("timer reset strobe short");
  property p_tcause; $fell(timer_reset_n) |-> $past(tmr_wr); endproperty
  a_tcause: assert property (p_tcause) else $error("timer reset without write");
  property p_rcause; $fell(reconfig_n) |-> $past(rcf_wr); endproperty
  a_rcause: assert property (p_rcause) else $error("reconfig without write");
  property p_half; !$past(srst) && !$past(srst, 2) |->
    upgrade_block_clock != $past(upgrade_block_clock); endproperty
  a_half: assert property (p_half) else $error("upgrade clock not halved");
  property p_upd; upgrade_update |-> upgrade_select == TARGET_INPUT; endproperty
  a_upd: assert property (p_upd) else $error("update on wrong chain");

  c_prev_two: cover property (upgrade_capture && upgrade_select == TARGET_PREV_TWO);
  c_update: cover property (upgrade_update);
  c_timer: cover property ($fell(timer_reset_n));
endmodule // dual_image_upgrade_regs_properties

bind dual_image_upgrade_regs dual_image_upgrade_regs_properties props_u (.core_clk, .srst,
  .avs_address, .avs_write, .avs_writedata, .avs_read, .avs_readdata, .avs_readdatavalid,
  .upgrade_block_clock, .upgrade_select, .upgrade_capture, .upgrade_update, .timer_reset_n,
  .reconfig_n);

`default_nettype wire

// >>> tb/dual_image_upgrade_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none

module dual_image_upgrade_regs_bench
  import upgrade_regs_pkg::*;
;
  localparam logic [28:0] WD_COUNT = 29'h15a3c6e9;
  localparam logic [3:0] WD_STATE = 4'ha;
  localparam logic [7:0] PREV_ONE = 8'h5c;
  localparam logic [7:0] PREV_TWO = 8'h93;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic avs_write = 1'b0;
  logic avs_read = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata;
  logic avs_readdatavalid, upgrade_block_clock, upgrade_capture, upgrade_update;
  logic upgrade_shift, upgrade_din, upgrade_dout, timer_reset_n, reconfig_n;
  logic [1:0] upgrade_select;
  int mismatches = 0;
  int num_checks = 0;

  always #50 core_clk = ~core_clk;

  dual_image_upgrade_regs dut_u (.core_clk, .srst, .avs_address, .avs_write, .avs_writedata,
    .avs_read, .avs_readdata, .avs_readdatavalid, .upgrade_block_clock, .upgrade_select,
    .upgrade_capture, .upgrade_update, .upgrade_shift, .upgrade_din, .upgrade_dout,
    .timer_reset_n, .reconfig_n);

  upgrade_block_model #(.WD_COUNT(WD_COUNT), .WD_EN(1'b1), .WD_STATE(WD_STATE),
    .PREV_ONE(PREV_ONE), .PREV_TWO(PREV_TWO)) model_u (.upgrade_block_clock,
    .upgrade_select, .upgrade_capture, .upgrade_update, .upgrade_shift, .upgrade_din,
    .upgrade_dout);

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    avs_read <= 1'b1;
    avs_address <= a;
    @(posedge core_clk);
    avs_read <= 1'b0;
    #1;
    rdata = avs_readdata;
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    rdata = 32'h1;
    while (rdata[0] !== 1'b0) begin
      if (n > 1000) begin
        mismatches++;
        end_of_test();
      end
      rd(OFS_BUSY);
      n += 2;
    end
  endtask

  task automatic s_command;
    wr(OFS_COMMAND, 32'h0);
    #1 check(32'({timer_reset_n, reconfig_n}), 32'h3);
    wr(OFS_COMMAND, 32'h3);
    for (int i = 0; i < 4; i++) begin
      #1 check(32'({timer_reset_n, reconfig_n}), 32'h0);
      @(posedge core_clk);
    end
    #1 check(32'({timer_reset_n, reconfig_n}), 32'h3);
  endtask

  task automatic s_image;
    int n;
    for (int v = 0; v < 4; v++) begin
      wr(OFS_IMAGE_SELECT, 32'(v));
      wr(OFS_IMAGE_SELECT, 32'(3 - v));
      rd(OFS_BUSY);
      check(rdata, 32'h1);
      wait_idle(n);
      // busy began four cycles before polling
      check(32'(n + 2 <= MAX_BUSY_CYCLES), 32'h1);
      wr(OFS_FETCH, 32'h8);
      wait_idle(n);
      rd(OFS_IMAGE_READBACK);
      check(rdata, 32'(v));
    end
  endtask

  task automatic s_fetch;
    int n;
    // clear the input register so a stale readback cannot pass
    wr(OFS_IMAGE_SELECT, 32'h0);
    wait_idle(n);
    wr(OFS_FETCH, 32'hf);
    // only the timer reset passes while busy
    wr(OFS_COMMAND, 32'h3);
    #1 check(32'({timer_reset_n, reconfig_n}), 32'h1);
    wait_idle(n);
    // busy began two cycles before polling
    check(32'(n + 2 <= MAX_BUSY_CYCLES), 32'h1);
    rd(OFS_WATCHDOG);
    check(rdata, {15'h0, WD_STATE, 1'b1, WD_COUNT[28:17]});
    rd(OFS_PREV_ONE);
    check(rdata, {24'h0, PREV_ONE});
    rd(OFS_PREV_TWO);
    check(rdata, {24'h0, PREV_TWO});
    rd(OFS_IMAGE_READBACK);
    check(rdata, 32'h0);
    rd(OFS_FETCH);
    check(rdata, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    s_command();
    s_image();
    s_fetch();
    end_of_test();
  end
endmodule // dual_image_upgrade_regs_bench

`default_nettype wire
